// ### lhp_host_port.sv
`timescale 1ns/1ps
`include "lhp_regs.svh"
`default_nettype none
module lhp_host_port
  import lhp_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Host pins
  input  wire logic        host_sel_n,
  input  wire logic [1:0]  bus_mode,
  input  wire logic        shift_clk,
  input  wire logic        serial_in,
  input  wire logic        output_edge_select,
  input  wire logic        addr_latch_en,
  input  wire logic        moto_addr_strobe,
  input  wire logic        wr_n,
  input  wire logic        rd_n,
  input  wire logic        moto_data_strobe_n,
  input  wire logic        rw_sel,
  input  wire logic [7:0]  ad_in,
  output logic      [7:0]  ad_out,
  output logic             ad_oe,
  output logic             serial_out,
  output logic             serial_out_oe,
  output logic             ack_n,
  output logic             ack_oe,
  output logic             rdy,
  output logic             rdy_oe,
  output logic             irq_out,
  output logic             irq_oe,
  // Core side
  input  wire logic [15:0] irq_src,
  output logic      [7:0]  global_config,
  output logic      [15:0] interrupt_mask
);
  localparam logic [3:0] ACK_CYC = 4'(`LHP_ACK_CYC);

  // ==========================================
  // Pin synchroniser
  lhp_pins_t raw, meta, p, q;
  assign raw = '{cs_n: host_sel_n, sclk: shift_clk, sin: serial_in,
                 oes: output_edge_select, ale: addr_latch_en,
                 as: moto_addr_strobe, wr_n: wr_n, rd_n: rd_n,
                 dstb_n: moto_data_strobe_n, rw: rw_sel, ad: ad_in,
                 mode: bus_mode};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, dstb_n: 1'b1, default: '0};
      p    <= '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, dstb_n: 1'b1, default: '0};
      q    <= '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, dstb_n: 1'b1, default: '0};
    end else begin
      meta <= raw;
      p    <= meta;
      q    <= p;
    end
  end

  // ==========================================
  // Register read decode
  function automatic logic [7:0] lhp_read(input logic [7:0] a, input lhp_state_t s,
                                          input logic [15:0] stat);
    case (a)
      `LHP_ADDR_CFG:     lhp_read = s.cfg;
      `LHP_ADDR_MASK_LO: lhp_read = s.msk0;
      `LHP_ADDR_MASK_HI: lhp_read = s.msk1;
      `LHP_ADDR_STAT_LO: lhp_read = stat[7:0];
      `LHP_ADDR_STAT_HI: lhp_read = stat[15:8];
      default:           lhp_read = 8'h00;
    endcase
  endfunction

  // ==========================================
  // Port state
  lhp_state_t st, next_st;
  logic       ser_act, spair, moto, sclk_rise, sclk_fall;
  logic       strobe, rd_act, wen, irq_act;
  logic [7:0] waddr, wdata;
  logic [1:0] style;

  assign ser_act   = (p.mode == LHP_SERIAL) && !p.cs_n;
  assign spair     = (p.mode == LHP_STRB) && !p.cs_n;
  assign moto      = (p.mode == LHP_MOTO) && !p.cs_n;
  assign sclk_rise = p.sclk && !q.sclk;
  assign sclk_fall = !p.sclk && q.sclk;
  assign strobe    = (spair && (!p.rd_n || !p.wr_n)) || (moto && !p.dstb_n);
  assign rd_act    = (spair && !p.rd_n) || (moto && !p.dstb_n && p.rw);
  assign irq_act   = |(irq_src & ~{st.msk1, st.msk0});
  assign style     = st.cfg[`LHP_IRQ_STYLE_MSB:`LHP_IRQ_STYLE_LSB];

  always_comb begin
    next_st = st;
    wen     = 1'b0;
    waddr   = 8'h00;
    wdata   = 8'h00;
    // Serial access
    if (!ser_act) begin
      next_st.scnt   = 5'd0;
      next_st.sstart = 1'b0;
    end else begin
      if (sclk_rise && st.scnt < `LHP_SER_FRAME) begin
        next_st.scnt = st.scnt + 5'd1;
        if (st.scnt < `LHP_SER_CMD_BITS) begin
          next_st.cmd = {st.cmd[6:0], p.sin};
        end else if (!st.cmd[`LHP_SER_RW_BIT]) begin
          next_st.wdat = {st.wdat[6:0], p.sin};
          if (st.scnt == `LHP_SER_FRAME - 5'd1) begin
            wen   = 1'b1;
            waddr = {1'b0, st.cmd[6:0]};
            wdata = {st.wdat[6:0], p.sin};
          end
        end else if (!p.oes) begin
          next_st.sout = {st.sout[6:0], 1'b0};
        end
        if (st.scnt == `LHP_SER_CMD_BITS - 5'd1 && st.cmd[6]) begin
          next_st.sout   = lhp_read({1'b0, st.cmd[5:0], p.sin}, st, irq_src);
          next_st.sstart = !p.oes;
        end
      end
      if (sclk_fall && p.oes && st.cmd[`LHP_SER_RW_BIT] && st.scnt >= `LHP_SER_CMD_BITS) begin
        if (st.sstart) begin
          next_st.sout = {st.sout[6:0], 1'b0};
        end else begin
          next_st.sstart = 1'b1;
        end
      end
    end
    // Parallel access
    if (spair && !p.ale && q.ale) begin
      next_st.paddr = p.ad;
    end
    if (moto && !p.as && q.as) begin
      next_st.paddr = p.ad;
    end
    if (!strobe) begin
      next_st.pcnt = 4'd0;
    end else if (st.pcnt != ACK_CYC) begin
      next_st.pcnt = st.pcnt + 4'd1;
    end
    if (rd_act) begin
      next_st.pdat = lhp_read(st.paddr, st, irq_src);
    end
    if ((spair && p.wr_n && !q.wr_n) || (moto && p.dstb_n && !q.dstb_n && !p.rw)) begin
      wen   = 1'b1;
      waddr = st.paddr;
      wdata = p.ad;
    end
    // Register writes
    if (wen) begin
      case (waddr)
        `LHP_ADDR_CFG:     next_st.cfg  = wdata;
        `LHP_ADDR_MASK_LO: next_st.msk0 = wdata;
        `LHP_ADDR_MASK_HI: next_st.msk1 = wdata;
        default:           next_st.cfg  = st.cfg;
      endcase
    end
    // Interrupt pin style
    case (style)
      LHP_PP_HIGH: begin
        next_st.irq_q  = irq_act;
        next_st.irq_oe = 1'b1;
      end
      LHP_PP_LOW: begin
        next_st.irq_q  = !irq_act;
        next_st.irq_oe = 1'b1;
      end
      default: begin
        next_st.irq_q  = 1'b0;
        next_st.irq_oe = irq_act;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st      <= '0;
      st.cfg  <= `LHP_RST_CFG;
      st.msk0 <= `LHP_RST_MASK;
      st.msk1 <= `LHP_RST_MASK;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================
  // Outputs
  assign ad_out         = st.pdat;
  assign ad_oe          = rd_act;
  assign serial_out     = st.sout[7];
  assign serial_out_oe  = ser_act && st.sstart;
  assign ack_n          = !(moto && !p.dstb_n && st.pcnt == ACK_CYC);
  assign ack_oe         = moto;
  assign rdy            = !(spair && strobe && st.pcnt != ACK_CYC);
  assign rdy_oe         = spair;
  assign irq_out        = st.irq_q;
  assign irq_oe         = st.irq_oe;
  assign global_config  = st.cfg;
  assign interrupt_mask = {st.msk1, st.msk0};

  // ==========================================
  // Assertions
  a_idle_released: assert property (@(posedge clk) disable iff (rst)
    p.cs_n |-> !ad_oe && !serial_out_oe && !ack_oe && !rdy_oe)
    else $error("pins driven while deselected");
  a_ser_abort: assert property (@(posedge clk) disable iff (rst)
    (p.cs_n && !q.cs_n) |=> st.scnt == 5'd0 && !st.sstart)
    else $error("serial state not cleared on deselect");
  a_sin_sample: assert property (@(posedge clk) disable iff (rst)
    ser_act && sclk_rise && st.scnt < `LHP_SER_CMD_BITS |=> st.cmd[0] == $past(p.sin))
    else $error("serial input not sampled");
  a_sout_edge: assert property (@(posedge clk) disable iff (rst)
    ser_act && st.sstart && st.scnt >= `LHP_SER_CMD_BITS && st.scnt < `LHP_SER_FRAME
      && st.cmd[`LHP_SER_RW_BIT] && ((p.oes && sclk_fall) || (!p.oes && sclk_rise))
    |=> st.sout == {$past(st.sout[6:0]), 1'b0})
    else $error("serial output shifted on wrong edge");
  a_ale_addr: assert property (@(posedge clk) disable iff (rst)
    spair && $fell(p.ale) |=> st.paddr == $past(p.ad))
    else $error("address not latched on latch enable");
  a_as_addr: assert property (@(posedge clk) disable iff (rst)
    moto && $fell(p.as) |=> st.paddr == $past(p.ad))
    else $error("address not latched on address strobe");
  a_spair_write: assert property (@(posedge clk) disable iff (rst)
    spair && $rose(p.wr_n) && st.paddr == `LHP_ADDR_CFG |=> st.cfg == $past(p.ad))
    else $error("write data not captured");
  a_moto_ack: assert property (@(posedge clk) disable iff (rst)
    (moto && !p.dstb_n)[*4] |-> !ack_n)
    else $error("acknowledge missing");
  a_rdy_busy: assert property (@(posedge clk) disable iff (rst)
    spair && $fell(p.rd_n) |-> !rdy ##1 !rdy)
    else $error("ready not low during access");
  a_bus_drive: assert property (@(posedge clk) disable iff (rst)
    ad_oe |-> !p.cs_n && (p.mode == LHP_MOTO ? p.rw && !p.dstb_n
                                             : p.mode == LHP_STRB && !p.rd_n))
    else $error("bus driven outside read strobe");
  a_irq_style: assert property (@(posedge clk) disable iff (rst)
    style == 2'b00 |=> irq_out == $past(irq_act) && irq_oe)
    else $error("interrupt output wrong");
endmodule
`default_nettype wire

// ### lhp_regs.svh
`ifndef LHP_REGS_SVH
`define LHP_REGS_SVH
// ==========================================
// Register offsets
`define LHP_ADDR_CFG      8'h02
`define LHP_ADDR_MASK_LO  8'h14
`define LHP_ADDR_MASK_HI  8'h15
`define LHP_ADDR_STAT_LO  8'h19
`define LHP_ADDR_STAT_HI  8'h1a
// ==========================================
// Reset values and fields
`define LHP_RST_CFG       8'h00
`define LHP_RST_MASK      8'hff
`define LHP_IRQ_STYLE_MSB 1
`define LHP_IRQ_STYLE_LSB 0
`define LHP_SER_RW_BIT    7
`define LHP_SER_CMD_BITS  5'd8
`define LHP_SER_FRAME     5'd16
// ==========================================
// Timing
`define LHP_CLK_NS        10
`define LHP_ACK_NS        30
`define LHP_ACK_CYC       (((`LHP_ACK_NS) + (`LHP_CLK_NS) - 1) / (`LHP_CLK_NS))
`endif

// ### lhp_pkg.sv
`default_nettype none
package lhp_pkg;
  typedef enum logic [1:0] {
    LHP_HW     = 2'b00,
    LHP_SERIAL = 2'b01,
    LHP_MOTO   = 2'b10,
    LHP_STRB   = 2'b11
  } lhp_bus_mode_t;

  typedef enum logic [1:0] {
    LHP_PP_HIGH = 2'b00,
    LHP_PP_LOW  = 2'b01,
    LHP_OD_LOW  = 2'b10
  } lhp_irq_style_t;

  typedef struct packed {
    logic       cs_n;
    logic       sclk;
    logic       sin;
    logic       oes;
    logic       ale;
    logic       as;
    logic       wr_n;
    logic       rd_n;
    logic       dstb_n;
    logic       rw;
    logic [7:0] ad;
    logic [1:0] mode;
  } lhp_pins_t;

  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] msk0;
    logic [7:0] msk1;
    logic [4:0] scnt;
    logic [7:0] cmd;
    logic [7:0] wdat;
    logic [7:0] sout;
    logic       sstart;
    logic [7:0] paddr;
    logic [7:0] pdat;
    logic [3:0] pcnt;
    logic       irq_q;
    logic       irq_oe;
  } lhp_state_t;
endpackage
`default_nettype wire

// ### lhp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module lhp_host_model
  import lhp_pkg::*;
(
  // Clock
  input  wire logic       clk,
  // Device pins
  input  wire logic [7:0] ad_out,
  input  wire logic       ad_oe,
  input  wire logic       serial_out,
  input  wire logic       ack_n,
  input  wire logic       rdy,
  // Host pins
  output var  lhp_pins_t  p
);
  // ==========================================
  // Bus level, the host's own p.ad drive when released
  logic [7:0] bus;
  assign bus = ad_oe ? ad_out : p.ad;
  initial begin
    p = '0;
    p.cs_n = 1'b1;
    p.wr_n = 1'b1;
    p.rd_n = 1'b1;
    p.dstb_n = 1'b1;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // ==========================================
  // One byte in either parallel style
  task automatic par(input logic moto, rd, input logic [7:0] a, w,
                     output logic [7:0] r, output logic bsy, ok);
    int n;
    step(1);
    p.cs_n = 1'b0;
    p.ad = a;
    p.rw = rd;
    if (moto) p.as = 1'b1;
    else p.ale = 1'b1;
    step(4);
    p.as = 1'b0;
    p.ale = 1'b0;
    step(4);
    p.ad = rd ? 8'h00 : w;
    if (moto) p.dstb_n = 1'b0;
    else if (rd) p.rd_n = 1'b0;
    else p.wr_n = 1'b0;
    step(3);
    bsy = moto ? (ack_n === 1'b1) : (rdy === 1'b0);
    n = 0;
    while (!(moto ? ack_n === 1'b0 : rdy === 1'b1) && n < 20) begin
      step(1);
      n++;
    end
    ok = (n < 20);
    r = bus;
    p.dstb_n = 1'b1;
    p.rd_n = 1'b1;
    p.wr_n = 1'b1;
    step(4);
    p.ad = 8'h00;
    p.cs_n = 1'b1;
    step(4);
  endtask
  // ==========================================
  // Serial frame, cut short when nb is below 16
  task automatic ser(input logic oes, rd, input logic [6:0] a,
                     input logic [7:0] w, input int nb, output logic [7:0] r);
    logic [15:0] f;
    f = {rd, a, w};
    r = 8'h00;
    step(1);
    p.oes = oes;
    p.cs_n = 1'b0;
    for (int i = 0; i < nb; i++) begin
      p.sin = f[15-i];
      #38;
      if (oes && i >= 8) r = {r[6:0], serial_out};
      #2 p.sclk = 1'b1;
      #38;
      if (!oes && i >= 7 && i < 15) r = {r[6:0], serial_out};
      #2 p.sclk = 1'b0;
    end
    #40 p.cs_n = 1'b1;
    p.sin = ~p.sin;
    step(6);
  endtask
endmodule
`default_nettype wire

// ### line_unit_host_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module line_unit_host_port_tb;
  import lhp_pkg::*;
  logic clk, rst, ad_oe, so, so_oe, ack_n, ack_oe, rdy, rdy_oe, irq, irq_oe;
  logic [1:0] mode;
  logic [7:0] ad_out, gcfg, w, r;
  logic [15:0] src, imask;
  lhp_pins_t p;
  int n_mismatch, n_tests;
  int mdl [int];
  logic [7:0] al [6] = '{8'h02, 8'h14, 8'h15, 8'h19, 8'h1a, 8'h40};
  lhp_bus_mode_t ms [4] = '{LHP_SERIAL, LHP_SERIAL, LHP_MOTO, LHP_STRB};
  lhp_host_port dut (.clk(clk), .rst(rst), .host_sel_n(p.cs_n), .bus_mode(mode),
    .shift_clk(p.sclk), .serial_in(p.sin), .output_edge_select(p.oes),
    .addr_latch_en(p.ale), .moto_addr_strobe(p.as), .wr_n(p.wr_n), .rd_n(p.rd_n),
    .moto_data_strobe_n(p.dstb_n), .rw_sel(p.rw), .ad_in(ad_oe ? ad_out : p.ad),
    .ad_out(ad_out), .ad_oe(ad_oe), .serial_out(so), .serial_out_oe(so_oe),
    .ack_n(ack_n), .ack_oe(ack_oe), .rdy(rdy), .rdy_oe(rdy_oe), .irq_out(irq), .irq_oe(irq_oe),
    .irq_src(src), .global_config(gcfg), .interrupt_mask(imask));
  lhp_host_model host (.clk(clk), .ad_out(ad_out), .ad_oe(ad_oe),
    .serial_out(so), .ack_n(ack_n), .rdy(rdy), .p(p));
  // ==========================================
  // Checking
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    if (a == 8'h19) return src[7:0];
    if (a == 8'h1a) return src[15:8];
    return mdl.exists(a) ? 8'(mdl[a]) : 8'h00;
  endfunction
  task automatic acc(input lhp_bus_mode_t m, input logic oes, rd, input logic [7:0] a, d);
    logic bsy, ok;
    mode = m;
    host.step(4);
    if (m == LHP_SERIAL) host.ser(oes, rd, a[6:0], d, 16, r);
    else begin
      host.par(m == LHP_MOTO, rd, a, d, r, bsy, ok);
      chk("busy", 16'(bsy), 16'h1);
      chk("done", 16'(ok), 16'h1);
    end
    if (rd) chk("read", 16'(r), 16'(exp_rd(a)));
    else if (mdl.exists(a)) mdl[a] = int'(d);
    chk("oe", 16'({ack_oe, rdy_oe, so_oe, ad_oe}), 16'h0);
    chk("cfg", 16'(gcfg), 16'(mdl[2]));
    chk("mask", imask, {8'(mdl[21]), 8'(mdl[20])});
  endtask
  task automatic irq_chk();
    logic a;
    logic [1:0] s;
    logic [1:0] e;
    host.step(4);
    a = |(src & ~{8'(mdl[21]), 8'(mdl[20])});
    s = 2'(mdl[2]);
    e = (s == 2'd0) ? {1'b1, a} : (s == 2'd1) ? {1'b1, ~a} : {a, 1'b0};
    chk("irq", 16'({irq_oe, irq}), 16'(e));
  endtask
  // ==========================================
  // Stimulus
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #500000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    void'($urandom(43));
    rst = 1'b1;
    mode = LHP_HW;
    src = 16'h0000;
    mdl[2] = 0;
    mdl[20] = 255;
    mdl[21] = 255;
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    for (int k = 0; k < 4; k++) begin
      src = 16'($urandom);
      for (int i = 0; i < 6; i++) begin
        w = 8'($urandom);
        if (i == 0) w[1:0] = 2'(k);
        acc(ms[k], k[0], 1'b0, al[i], w);
      end
      for (int i = 0; i < 6; i++) acc(ms[k], k[0], 1'b1, al[i], 8'h00);
      irq_chk();
      mode = LHP_SERIAL;
      host.ser(1'b0, 1'b0, 7'h02, 8'hff, 5, r);
      acc(LHP_SERIAL, k[0], 1'b1, 8'h02, 8'h00);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
